/* File: opv_pkg.sv */
// Constants and types for the one-time-programmable memory programmer
// How it works
// - Each program pulse holds chip enable low 47.5 to 52.5 us, aiming 50 us.
// - Programming starts with the address pointer at the first location.
// - Every address first gets exactly one pulse with no verify read.
// - A second pass reads each word back and compares it to the source.
// - A failing word gets up to ten more pulses, each followed by a verify.
// - Still failing after ten retry pulses stops the run and flags part failed.
// - A verified word advances the address until every address is done.
// - At read supply levels every word is read again; overall pass or fail reported.
package opv_pkg;
  // ************************************************************
  // Geometry and timing
  // ************************************************************
  localparam int ADDR_W = 18;
  localparam int DATA_W = 16;
  localparam int CLK_PERIOD_NS = 8;
  localparam int PULSE_NOM_NS = 50000;
  localparam int PULSE_MIN_NS = 47500;
  localparam int PULSE_MAX_NS = 52500;
  localparam int PULSE_CYC = PULSE_NOM_NS / CLK_PERIOD_NS;
  localparam int PULSE_MIN_CYC = (PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PULSE_MAX_CYC = PULSE_MAX_NS / CLK_PERIOD_NS;
  localparam int SETUP_NS = 2000;
  localparam int SETUP_CYC = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int READ_NS = 200;
  localparam int READ_CYC = (READ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TMR_W = 16;
  localparam logic [3:0] MAX_RETRY = 4'ha;
  localparam logic [ADDR_W-1:0] ADDR_FIRST = 18'h00000;
  localparam int IMG_DEPTH = 1 << ADDR_W;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000,
    ST_SETUP = 4'b0001,
    ST_PULSE = 4'b0010,
    ST_GAP = 4'b0011,
    ST_READ = 4'b0100,
    ST_CHECK = 4'b0101,
    ST_SUPPLY = 4'b0110,
    ST_FREAD = 4'b0111,
    ST_FCHECK = 4'b1000,
    ST_IDREAD = 4'b1001,
    ST_DONE = 4'b1010
  } opv_state_t;

  typedef enum logic [1:0] {
    PH_FIRST = 2'b00,
    PH_VERIFY = 2'b01,
    PH_FINAL = 2'b10
  } opv_phase_t;
endpackage

/* File: opv_image_mem.sv */
// Source image memory holding the words to be programmed
module opv_image_mem
  import opv_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic wr_en_i,
  input wire logic [ADDR_W-1:0] wr_addr_i,
  input wire logic [DATA_W-1:0] wr_data_i,
  input wire logic [ADDR_W-1:0] rd_addr_i,
  output logic [DATA_W-1:0] rd_data_o
);
  logic [DATA_W-1:0] mem [IMG_DEPTH];

  always_ff @(posedge core_clk_i) begin
    if (wr_en_i) begin
      mem[wr_addr_i] <= wr_data_i;
    end
    rd_data_o <= mem[rd_addr_i];
  end
endmodule

/* File: opv_programmer.sv */
// Pin-level programmer that writes, verifies and identifies the memory
module opv_programmer
  import opv_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic resetn_i,
  input wire logic load_en_i,
  input wire logic [ADDR_W-1:0] load_addr_i,
  input wire logic [DATA_W-1:0] load_data_i,
  input wire logic [ADDR_W-1:0] last_addr_i,
  input wire logic prog_start_i,
  input wire logic id_start_i,
  input wire logic id_select_i,
  input wire logic [DATA_W-1:0] mem_data_i,
  output logic [ADDR_W-1:0] mem_addr_o,
  output logic [DATA_W-1:0] mem_data_o,
  output logic mem_data_oe_o,
  output logic mem_cen_o,
  output logic mem_oen_o,
  output logic prog_supply_o,
  output logic id_mode_high_voltage_o,
  output logic busy_o,
  output logic done_o,
  output logic pass_o,
  output logic fail_o,
  output logic [DATA_W-1:0] id_code_o,
  output logic id_valid_o
);
  // ************************************************************
  // Pin synchroniser and image memory
  // ************************************************************
  logic [DATA_W-1:0] din_meta_reg, din_reg;
  logic [DATA_W-1:0] img_data;
  logic [ADDR_W-1:0] img_addr;

  always_ff @(posedge core_clk_i) begin
    din_meta_reg <= mem_data_i;
    din_reg <= din_meta_reg;
  end

  opv_image_mem u_img (
    .core_clk_i(core_clk_i),
    .wr_en_i(load_en_i),
    .wr_addr_i(load_addr_i),
    .wr_data_i(load_data_i),
    .rd_addr_i(img_addr),
    .rd_data_o(img_data)
  );

  // ************************************************************
  // Sequencer
  // ************************************************************
  opv_state_t state_reg, state_next;
  opv_phase_t phase_reg, phase_next;
  logic [TMR_W-1:0] tmr_reg, tmr_next;
  logic [3:0] retry_reg, retry_next;
  logic [ADDR_W-1:0] addr_reg, addr_next;
  logic final_ok_reg, final_ok_next;
  logic id_sel_reg, id_sel_next;

  wire tmr_zero = (tmr_reg == '0);
  wire is_last = (addr_reg == last_addr_i);
  wire match = (din_reg == img_data);
  wire [ADDR_W-1:0] addr_inc = addr_reg + ADDR_W'(1);
  assign img_addr = addr_reg;

  always_comb begin
    state_next = state_reg;
    phase_next = phase_reg;
    tmr_next = tmr_zero ? tmr_reg : tmr_reg - TMR_W'(1);
    retry_next = retry_reg;
    addr_next = addr_reg;
    final_ok_next = final_ok_reg;
    id_sel_next = id_sel_reg;
    case (state_reg)
      ST_IDLE: begin
        if (prog_start_i) begin
          addr_next = ADDR_FIRST;
          phase_next = PH_FIRST;
          retry_next = '0;
          final_ok_next = 1'b1;
          tmr_next = TMR_W'(SETUP_CYC);
          state_next = ST_SETUP;
        end else if (id_start_i) begin
          id_sel_next = id_select_i;
          tmr_next = TMR_W'(SETUP_CYC);
          state_next = ST_IDREAD;
        end
      end
      ST_SETUP: begin
        if (tmr_zero) begin
          if (phase_reg == PH_FIRST) begin
            tmr_next = TMR_W'(PULSE_CYC);
            state_next = ST_PULSE;
          end else begin
            tmr_next = TMR_W'(READ_CYC);
            state_next = phase_reg == PH_FINAL ? ST_FREAD : ST_READ;
          end
        end
      end
      ST_PULSE: begin
        if (tmr_zero) begin
          tmr_next = TMR_W'(SETUP_CYC);
          state_next = ST_GAP;
        end
      end
      ST_GAP: begin
        if (tmr_zero) begin
          if (phase_reg == PH_FIRST) begin
            // one pulse per address, no verify
            if (is_last) begin
              addr_next = ADDR_FIRST;
              phase_next = PH_VERIFY;
            end else begin
              addr_next = addr_inc;
            end
            tmr_next = TMR_W'(SETUP_CYC);
            state_next = ST_SETUP;
          end else begin
            tmr_next = TMR_W'(READ_CYC);
            state_next = ST_READ;
          end
        end
      end
      ST_READ: begin
        if (tmr_zero) begin
          state_next = ST_CHECK;
        end
      end
      ST_CHECK: begin
        if (match) begin
          retry_next = '0;
          if (is_last) begin
            addr_next = ADDR_FIRST;
            tmr_next = TMR_W'(SETUP_CYC);
            state_next = ST_SUPPLY;
          end else begin
            addr_next = addr_inc;
            tmr_next = TMR_W'(SETUP_CYC);
            state_next = ST_SETUP;
          end
        end else if (retry_reg == MAX_RETRY) begin
          final_ok_next = 1'b0;
          state_next = ST_DONE;
        end else begin
          retry_next = retry_reg + 4'h1;
          tmr_next = TMR_W'(PULSE_CYC);
          state_next = ST_PULSE;
        end
      end
      ST_SUPPLY: begin
        if (tmr_zero) begin
          phase_next = PH_FINAL;
          tmr_next = TMR_W'(READ_CYC);
          state_next = ST_FREAD;
        end
      end
      ST_FREAD: begin
        if (tmr_zero) begin
          state_next = ST_FCHECK;
        end
      end
      ST_FCHECK: begin
        if (!match) begin
          final_ok_next = 1'b0;
        end
        if (is_last) begin
          state_next = ST_DONE;
        end else begin
          addr_next = addr_inc;
          tmr_next = TMR_W'(SETUP_CYC);
          state_next = ST_SETUP;
        end
      end
      ST_IDREAD: begin
        if (tmr_zero) begin
          state_next = ST_DONE;
        end
      end
      ST_DONE: begin
        state_next = ST_IDLE;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      state_reg <= ST_IDLE;
      phase_reg <= PH_FIRST;
      tmr_reg <= '0;
      retry_reg <= '0;
      addr_reg <= ADDR_FIRST;
      final_ok_reg <= 1'b0;
      id_sel_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      phase_reg <= phase_next;
      tmr_reg <= tmr_next;
      retry_reg <= retry_next;
      addr_reg <= addr_next;
      final_ok_reg <= final_ok_next;
      id_sel_reg <= id_sel_next;
    end
  end

  // ************************************************************
  // Registered pin and status outputs
  // ************************************************************
  wire in_prog = (state_next != ST_IDLE) && (state_next != ST_IDREAD) && (state_next != ST_DONE);
  wire hi_supply = in_prog && (phase_next != PH_FINAL) && (state_next != ST_SUPPLY);
  wire reading = (state_next == ST_READ) || (state_next == ST_FREAD) || (state_next == ST_IDREAD);
  wire drive_data = hi_supply && !reading;
  wire [ADDR_W-1:0] pin_addr = (state_next == ST_IDREAD) ? {{(ADDR_W-1){1'b0}}, id_sel_next} : addr_next;
  wire done_next = (state_reg != ST_DONE) && (state_next == ST_DONE);
  wire id_done = (state_reg == ST_IDREAD) && (state_next == ST_DONE);

  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      mem_addr_o <= '0;
      mem_data_o <= '0;
      mem_data_oe_o <= 1'b0;
      mem_cen_o <= 1'b1;
      mem_oen_o <= 1'b1;
      prog_supply_o <= 1'b0;
      id_mode_high_voltage_o <= 1'b0;
      busy_o <= 1'b0;
      done_o <= 1'b0;
      pass_o <= 1'b0;
      fail_o <= 1'b0;
      id_code_o <= '0;
      id_valid_o <= 1'b0;
    end else begin
      // address and data held; enable low only in pulse and read states
      mem_addr_o <= pin_addr;
      mem_data_o <= img_data;
      mem_data_oe_o <= drive_data;
      mem_cen_o <= !((state_next == ST_PULSE) || reading);
      mem_oen_o <= !reading;
      prog_supply_o <= hi_supply;
      id_mode_high_voltage_o <= (state_next == ST_IDREAD);
      busy_o <= (state_next != ST_IDLE);
      done_o <= done_next;
      if (prog_start_i && state_reg == ST_IDLE) begin
        pass_o <= 1'b0;
        fail_o <= 1'b0;
      end else if (done_next && !id_done) begin
        pass_o <= final_ok_next;
        fail_o <= !final_ok_next;
      end
      if (id_done) begin
        id_code_o <= din_reg;
      end
      id_valid_o <= id_done;
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  logic [TMR_W-1:0] low_cnt_reg;
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i || mem_cen_o || !mem_oen_o) begin
      low_cnt_reg <= '0;
    end else begin
      low_cnt_reg <= low_cnt_reg + TMR_W'(1);
    end
  end

  pulse_width_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    ($rose(mem_cen_o) && $past(mem_oen_o) && $past(low_cnt_reg) != 0) |->
      ($past(low_cnt_reg) >= TMR_W'(PULSE_MIN_CYC - 1) && $past(low_cnt_reg) <= TMR_W'(PULSE_MAX_CYC)))
    else $error("program pulse width out of range");

  start_first_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    (state_reg == ST_IDLE && prog_start_i) |=> (mem_addr_o == ADDR_FIRST && addr_reg == ADDR_FIRST))
    else $error("programming did not start at first address");

  first_no_verify_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    (phase_reg == PH_FIRST) |-> (state_reg != ST_READ && state_reg != ST_CHECK))
    else $error("verify read during first pass");

  retry_bound_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    retry_reg <= MAX_RETRY)
    else $error("too many retry pulses");

  fail_stop_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    (state_reg == ST_CHECK && !match && retry_reg == MAX_RETRY) |=> (fail_o && done_o && !pass_o))
    else $error("failed word not reported");

  advance_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    (state_reg == ST_CHECK && match && !is_last) |=> (addr_reg == $past(addr_inc) && mem_addr_o == $past(addr_inc)))
    else $error("address did not advance after verify");

  final_low_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    (state_reg == ST_FREAD) |-> !prog_supply_o)
    else $error("final read at programming supply");

  id_voltage_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    (state_reg == ST_IDREAD) |-> id_mode_high_voltage_o && !mem_oen_o)
    else $error("id read without raised line");

  id_select_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    (state_reg == ST_IDREAD) |-> (mem_addr_o[0] == id_sel_reg))
    else $error("code select line wrong");

  cen_gap_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    (state_reg == ST_GAP) |-> (mem_cen_o && $stable(mem_addr_o)))
    else $error("chip enable low or address moved in gap");
endmodule

/* File: opv_otp_model.sv */
// Behavioural model of the one-time-programmable memory device
module opv_otp_model
  import opv_pkg::*;
#(
  parameter logic [7:0] MAKER_CODE = 8'h3c, // Arbitrary value
  parameter logic [7:0] TYPE_CODE = 8'h5a // Arbitrary value
) (
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] data_i,
  input wire logic data_oe_i,
  input wire logic cen_i,
  input wire logic oen_i,
  input wire logic supply_i,
  input wire logic id_hv_i,
  input wire logic [ADDR_W-1:0] weak_addr_i,
  input wire logic [7:0] weak_need_i,
  output logic [DATA_W-1:0] data_o,
  output logic drive_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ************************************************************
  // Array, read path and event counters
  // ************************************************************
  logic [DATA_W-1:0] mem [IMG_DEPTH];
  int pcnt [IMG_DEPTH];
  int fin_rd, early_rd, b2b, bad_w, unstable, pulses;
  logic [ADDR_W-1:0] first_addr;
  logic pulsing, read_seen;
  realtime t0;
  logic [DATA_W-1:0] rd_val, last_val;

  task automatic clear();
    pulses = 0;
    fin_rd = 0;
    early_rd = 0;
    b2b = 0;
    bad_w = 0;
    unstable = 0;
    read_seen = 1'b0;
    foreach (pcnt[i]) pcnt[i] = 0;
  endtask

  initial begin
    pulsing = 1'b0;
    last_val = 16'h0000;
    foreach (mem[i]) mem[i] = 16'hffff;
    clear();
  end

  // id codes on both bytes under high voltage
  assign rd_val = id_hv_i ? (addr_i[0] ? {TYPE_CODE, TYPE_CODE} : {MAKER_CODE, MAKER_CODE}) : mem[addr_i];
  assign drive_o = !cen_i && !oen_i;
  // Released bus shows inverted last value
  assign data_o = drive_o ? rd_val : ~last_val;

  always @(negedge drive_o) begin
    last_val = rd_val;
    if (id_hv_i === 1'b0) begin
      read_seen = 1'b1;
      if (pulses < 2) early_rd++;
      if (!supply_i) fin_rd++;
    end
  end

  always @(negedge cen_i) begin
    if (data_oe_i && supply_i) begin
      pulsing = 1'b1;
      t0 = $realtime;
    end
  end

  // pulse width and verify between retries
  always @(posedge cen_i) begin
    if (pulsing) begin
      pulsing = 1'b0;
      if ($realtime - t0 < PULSE_MIN_NS || $realtime - t0 > PULSE_MAX_NS) bad_w++;
      if (pcnt[addr_i] > 0 && !read_seen) b2b++;
      if (pulses == 0) first_addr = addr_i;
      pulses++;
      pcnt[addr_i]++;
      read_seen = 1'b0;
      if (!(addr_i == weak_addr_i && pcnt[addr_i] < weak_need_i)) mem[addr_i] = mem[addr_i] & data_i;
    end
  end

  // address and data held through a pulse
  always @(addr_i or data_i) begin
    if (pulsing) unstable++;
  end
endmodule

/* File: opv_tb.sv */
// Self-checking testbench for the memory programmer
module testbench
  import opv_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] ID_MAKER = 8'h3c; // Arbitrary value
  localparam logic [7:0] ID_TYPE = 8'h5a; // Arbitrary value
  logic core_clk, resetn, load_en, prog_start, id_start, id_select;
  logic [ADDR_W-1:0] load_addr, last_addr, weak_addr, mem_addr;
  logic [DATA_W-1:0] load_data, mem_wire, dut_data, dev_data, id_code;
  logic data_oe, cen, oen, supply, id_hv, busy, done, pass, fail, id_valid, drive, saw_valid, saw_hv;
  logic [7:0] weak_need;
  int error_cnt = 0;
  int check_count = 0;

  assign mem_wire = data_oe ? dut_data : dev_data;
  always #4 core_clk = ~core_clk;

  opv_programmer dut_u (.core_clk_i(core_clk), .resetn_i(resetn), .load_en_i(load_en), .load_addr_i(load_addr),
    .load_data_i(load_data), .last_addr_i(last_addr), .prog_start_i(prog_start), .id_start_i(id_start),
    .id_select_i(id_select), .mem_data_i(mem_wire), .mem_addr_o(mem_addr), .mem_data_o(dut_data),
    .mem_data_oe_o(data_oe), .mem_cen_o(cen), .mem_oen_o(oen), .prog_supply_o(supply),
    .id_mode_high_voltage_o(id_hv), .busy_o(busy), .done_o(done), .pass_o(pass), .fail_o(fail),
    .id_code_o(id_code), .id_valid_o(id_valid));

  opv_otp_model #(.MAKER_CODE(ID_MAKER), .TYPE_CODE(ID_TYPE)) dev_u (.addr_i(mem_addr), .data_i(dut_data),
    .data_oe_i(data_oe), .cen_i(cen), .oen_i(oen), .supply_i(supply), .id_hv_i(id_hv),
    .weak_addr_i(weak_addr), .weak_need_i(weak_need), .data_o(dev_data), .drive_o(drive));

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    if (error_cnt == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic wait_done(input int limit);
    int n = 0;
    saw_valid = 1'b0;
    saw_hv = 1'b0;
    while (done !== 1'b1 && n < limit) begin
      @(negedge core_clk);
      n++;
      if (id_valid === 1'b1) saw_valid = 1'b1;
      if (id_hv === 1'b1) saw_hv = 1'b1;
    end
    check("done_seen", {31'h0, done}, 32'h1);
  endtask

  task automatic load(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(negedge core_clk);
    load_en = 1'b1;
    load_addr = a;
    load_data = d;
    @(negedge core_clk);
    load_en = 1'b0;
  endtask

  task automatic kick(input logic prog, input logic sel);
    @(negedge core_clk);
    prog_start = prog;
    id_start = !prog;
    id_select = sel;
    @(negedge core_clk);
    prog_start = 1'b0;
    id_start = 1'b0;
  endtask

  task automatic id_read(input logic sel);
    kick(1'b0, sel);
    wait_done(400);
    check("id_hv", {31'h0, saw_hv}, 32'h1);
    check("id_valid", {31'h0, saw_valid}, 32'h1);
    check("id_code", {16'h0, id_code}, {16'h0, sel ? {ID_TYPE, ID_TYPE} : {ID_MAKER, ID_MAKER}});
  endtask

  task automatic prog_ok();
    load(18'h00000, 16'h1234);
    load(18'h00001, 16'ha5c3);
    last_addr = 18'h00001;
    weak_addr = 18'h00001;
    weak_need = 8'h02;
    dev_u.clear();
    kick(1'b1, 1'b0);
    check("busy_run", {31'h0, busy}, 32'h1);
    wait_done(30000);
    check("pass", {31'h0, pass}, 32'h1);
    check("fail", {31'h0, fail}, 32'h0);
    check("first_addr", {14'h0, dev_u.first_addr}, 32'h0);
    check("early_reads", dev_u.early_rd, 32'h0);
    check("pulses_w0", dev_u.pcnt[0], 32'h1);
    check("pulses_w1", dev_u.pcnt[1], 32'h2);
    check("b2b", dev_u.b2b, 32'h0);
    check("bad_width", dev_u.bad_w, 32'h0);
    check("unstable", dev_u.unstable, 32'h0);
    check("word1", {16'h0, dev_u.mem[1]}, 32'ha5c3);
    check("final_reads", dev_u.fin_rd, 32'h2);
  endtask

  task automatic prog_fail();
    load(18'h00000, 16'h0f0f);
    last_addr = 18'h00000;
    weak_need = 8'h00;
    dev_u.clear();
    kick(1'b1, 1'b0);
    wait_done(80000);
    check("pass", {31'h0, pass}, 32'h0);
    check("fail", {31'h0, fail}, 32'h1);
    check("pulses_w0", dev_u.pcnt[0], 32'hb);
    check("b2b", dev_u.b2b, 32'h0);
    check("final_reads", dev_u.fin_rd, 32'h0);
    check("bad_width", dev_u.bad_w, 32'h0);
  endtask

  initial begin
    #1000000;
    error_cnt++;
    tally_and_finish();
  end

  initial begin
    core_clk = 1'b0;
    resetn = 1'b0;
    load_en = 1'b0;
    prog_start = 1'b0;
    id_start = 1'b0;
    id_select = 1'b0;
    load_addr = 18'h00000;
    load_data = 16'h0000;
    last_addr = 18'h00000;
    weak_addr = 18'h00000;
    weak_need = 8'h00;
    repeat (3) @(negedge core_clk);
    resetn = 1'b1;
    check("cen_idle", {31'h0, cen}, 32'h1);
    check("busy_idle", {31'h0, busy}, 32'h0);
    check("dev_quiet", {31'h0, drive}, 32'h0);
    id_read(1'b0);
    id_read(1'b1);
    prog_ok();
    prog_fail();
    tally_and_finish();
  end
endmodule
